// >>> include/pcs_pkg.sv
// Shared constants, register layouts and state types of the conversion sequencer.
// Assumes a single 10 MHz system clock and a host on the parallel data pins.
// Functional notes
// - Single mode converts chosen channel repeatedly.
// - Single mode repeats until next host write.
// - Start pin falling samples, rising converts.
// - Hardware sampling follows pin; conversion ten clocks.
// - Software start: write begins, then reads.
// - Software sampling six clocks, conversion ten.
// - Sweep converts one channel per start.
// - Sweep software start: read advances channel.
// - Interrupt style gives one pulse per conversion.
// - End style low during conversion, high after.
// - Result valid at completion output rise.
// - Single channel comes from register zero low bits.
// - No read one clock after: auto power-down.
// - Chip select high gives software power-down.
// - Power-down keeps registers; host waits minimum clocks.
// - Self-test codes 000h, 200h, 3FFh.
// - Both control registers read back.
// - Internal oscillator runs only during sampling and conversion.
// - External clock times sampling and conversion.
// - Output saturates at reference limits.
// - Top two data bits address the register.
// - Read with write held low loads zeros.
// - Clock source switches at write rising edge.
package pcs_pkg;

    localparam int DATA_W = 10;
    localparam int CH_W = 3;
    localparam int CNT_W = 4;
    localparam int ADDR_MSB = 9;
    localparam int ADDR_LSB = 8;
    localparam int REG_MSB = 7;

    localparam logic [1:0] ADDR_CR0 = 2'h0;
    localparam logic [1:0] ADDR_CR1 = 2'h1;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Conversion-clock counts for the two phases of a conversion.
    localparam logic [CNT_W-1:0] SAMPLE_TICKS = 4'h6;
    localparam logic [CNT_W-1:0] CONVERT_TICKS = 4'hA;
    localparam logic [CNT_W-1:0] TICK_ONE = 4'h1;
    localparam logic [CNT_W-1:0] TICK_ZERO = 4'h0;

    // Self-test selections and their fixed output codes.
    localparam logic [1:0] TEST_NONE = 2'h0;
    localparam logic [1:0] TEST_LOW = 2'h1;
    localparam logic [1:0] TEST_MID = 2'h2;
    localparam logic [1:0] TEST_HIGH = 2'h3;
    localparam logic [DATA_W-1:0] CODE_ZERO = 10'h000;
    localparam logic [DATA_W-1:0] CODE_MID = 10'h200;
    localparam logic [DATA_W-1:0] CODE_FULL = 10'h3FF;

    // Auto power-down waits one system clock for a read after completion.
    localparam int CLK_PERIOD_NS = 100;
    localparam int AUTO_PD_WAIT_NS = 100;
    localparam int AUTO_PD_CYCLES = (AUTO_PD_WAIT_NS / CLK_PERIOD_NS) < 1 ? 1 : (AUTO_PD_WAIT_NS / CLK_PERIOD_NS);
    localparam logic [1:0] AUTO_PD_LAST = 2'(AUTO_PD_CYCLES);
    localparam logic [1:0] AUTO_PD_ONE = 2'h1;
    localparam logic [1:0] AUTO_PD_IDLE = 2'h0;

    // Control register zero layout.
    typedef struct packed {
        logic trigger_source_sel;
        logic done_style_sel;
        logic clock_source_sel;
        logic soft_pwdn;
        logic scan_mode_sel;
        logic [CH_W-1:0] channel_pick;
    } pcs_cr0_s;

    // Control register one layout.
    typedef struct packed {
        logic rsvd7;
        logic osc_fast;
        logic rsvd5;
        logic rsvd4;
        logic output_format_sel;
        logic readback_enable;
        logic selftest_sel_hi;
        logic selftest_sel_lo;
    } pcs_cr1_s;

    // Host pins as one group, so they are synchronised together.
    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic trig_n;
        logic ext_clk;
        logic [DATA_W-1:0] data;
    } pcs_pins_s;

    localparam int PIN_W = $bits(pcs_pins_s);
    localparam logic [PIN_W-1:0] PIN_IDLE = {4'hF, 1'b0, 10'h000};

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE_HW,
        ST_SAMPLE_SW,
        ST_CONVERT
    } pcs_state_e;

endpackage

// >>> core/pcs_sync.sv
// Three-stage synchroniser for a group of pins.
// Assumes asynchronous inputs; a bit changes once stages two and three agree.
`timescale 1ns/10ps
module pcs_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;

    // ----------------------------------------------------------------
    // Stages
    // ----------------------------------------------------------------
    // The first stage feeds only the second one.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RESET_VAL;
            stage2_q <= RESET_VAL;
            stage3_q <= RESET_VAL;
        end else begin
            meta_q <= async_in;
            stage2_q <= meta_q;
            stage3_q <= stage2_q;
        end
    end

    // A bit is accepted only when the later two stages agree.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_out <= RESET_VAL;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_q[i] == stage3_q[i]) begin
                    sync_out[i] <= stage3_q[i];
                end
            end
        end
    end

endmodule // pcs_sync

// >>> core/pcs_sequencer.sv
// Conversion sequencer of a 10-bit, 8-input converter with a parallel host port.
// Assumes host strobes slow against the 10 MHz clock and an external conversion
// clock well below half the system clock; the analog value arrives as a code.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
module pcs_sequencer #(
    parameter int AIN_W = 12
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic hw_conv_trigger_n,
    input wire logic conv_clock,
    input wire logic [pcs_pkg::DATA_W-1:0] data_in,
    output logic [pcs_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [AIN_W-1:0] ain_level,
    input wire logic [AIN_W-1:0] ref_upper,
    input wire logic [AIN_W-1:0] ref_lower,
    output logic conv_status_n,
    output logic [pcs_pkg::CH_W-1:0] mux_channel,
    output logic sample_hold,
    output logic osc_enable,
    output logic auto_pd,
    output logic soft_pd
);

    // ----------------------------------------------------------------
    // Pin synchronisation and edges
    // ----------------------------------------------------------------
    pcs_pkg::pcs_pins_s pins_raw;
    pcs_pkg::pcs_pins_s pins_s;
    pcs_pkg::pcs_pins_s prev_q;
    pcs_pkg::pcs_cr0_s cr0_q;
    pcs_pkg::pcs_cr1_s cr1_q;
    pcs_pkg::pcs_state_e state_q;
    logic [pcs_pkg::CNT_W-1:0] cnt_q;
    logic [pcs_pkg::DATA_W-1:0] result_q;
    logic [1:0] ap_cnt_q;
    logic [1:0] test_sel;
    logic [1:0] wr_addr;
    logic wr_rise;
    logic rd_rise;
    logic rd_fall;
    logic dummy_rd;
    logic trig_fall;
    logic trig_rise;
    logic ext_rise;
    logic pd_now;
    logic new_sw;
    logic sw_start;
    logic conv_tick;
    logic conv_begin;
    logic conv_end;
    logic [pcs_pkg::CH_W-1:0] sweep_last;
    logic [pcs_pkg::DATA_W-1:0] adc_code;
    logic [pcs_pkg::DATA_W-1:0] conv_code;
    logic [pcs_pkg::DATA_W-1:0] readback_word;

    assign pins_raw = {cs_n, wr_n, rd_n, hw_conv_trigger_n, conv_clock, data_in};

    pcs_sync #(
        .WIDTH(pcs_pkg::PIN_W),
        .RESET_VAL(pcs_pkg::PIN_IDLE)
    ) u_pin_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    // Previous synchronised pin levels for edge detection.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= pcs_pkg::PIN_IDLE;
        end else begin
            prev_q <= pins_s;
        end
    end

    // Strobes count only while chip select is low.
    assign wr_rise = !pins_s.cs_n && !prev_q.wr_n && pins_s.wr_n;
    assign rd_rise = !pins_s.cs_n && !prev_q.rd_n && pins_s.rd_n && pins_s.wr_n;
    assign rd_fall = !pins_s.cs_n && prev_q.rd_n && !pins_s.rd_n;
    assign dummy_rd = !pins_s.cs_n && !prev_q.rd_n && pins_s.rd_n && !pins_s.wr_n;
    assign trig_fall = prev_q.trig_n && !pins_s.trig_n;
    assign trig_rise = !prev_q.trig_n && pins_s.trig_n;
    assign ext_rise = !prev_q.ext_clk && pins_s.ext_clk;
    assign pd_now = pins_s.cs_n || cr0_q.soft_pwdn;
    assign wr_addr = pins_s.data[pcs_pkg::ADDR_MSB:pcs_pkg::ADDR_LSB];

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Writes land at the write rising edge; a dummy read with write low loads defaults.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cr0_q <= pcs_pkg::CTRL_RESET;
            cr1_q <= pcs_pkg::CTRL_RESET;
        end else if (dummy_rd) begin
            cr0_q <= pcs_pkg::CTRL_RESET;
            cr1_q <= pcs_pkg::CTRL_RESET;
        end else if (wr_rise) begin
            if (wr_addr == pcs_pkg::ADDR_CR0) begin
                cr0_q <= pins_s.data[pcs_pkg::REG_MSB:0];
            end else if (wr_addr == pcs_pkg::ADDR_CR1) begin
                cr1_q <= pins_s.data[pcs_pkg::REG_MSB:0];
            end
        end
    end

    // The write that selects software start also starts the first sample.
    always_comb begin
        new_sw = cr0_q.trigger_source_sel;
        if (wr_rise && wr_addr == pcs_pkg::ADDR_CR0) begin
            new_sw = pins_s.data[pcs_pkg::REG_MSB];
        end
    end

    assign sw_start = new_sw && (wr_rise || rd_rise) && !pd_now;

    // ----------------------------------------------------------------
    // Conversion clock
    // ----------------------------------------------------------------
    // External edges pace the phases, else the gated oscillator runs one tick a clock.
    assign conv_tick = cr0_q.clock_source_sel ? ext_rise : osc_enable;

    // The oscillator starts at a trigger and stops when the conversion ends or a write aborts it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_enable <= 1'b0;
        end else if (pd_now || conv_end || (wr_rise && !sw_start)) begin
            osc_enable <= 1'b0;
        end else if (sw_start || (trig_fall && !cr0_q.trigger_source_sel)) begin
            osc_enable <= !cr0_q.clock_source_sel;
        end
    end

    // ----------------------------------------------------------------
    // Sequencing state machine
    // ----------------------------------------------------------------
    assign conv_begin = !pd_now && !wr_rise && ((state_q == pcs_pkg::ST_SAMPLE_HW && trig_rise)
        || (state_q == pcs_pkg::ST_SAMPLE_SW && conv_tick && cnt_q == pcs_pkg::SAMPLE_TICKS - pcs_pkg::TICK_ONE));
    assign conv_end = !pd_now && !wr_rise && state_q == pcs_pkg::ST_CONVERT && conv_tick
        && cnt_q == pcs_pkg::CONVERT_TICKS - pcs_pkg::TICK_ONE;

    // Power-down and host writes abort a conversion; a software-start write restarts it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= pcs_pkg::ST_IDLE;
            cnt_q <= pcs_pkg::TICK_ZERO;
        end else if (pd_now) begin
            state_q <= pcs_pkg::ST_IDLE;
            cnt_q <= pcs_pkg::TICK_ZERO;
        end else if (sw_start && (wr_rise || state_q == pcs_pkg::ST_IDLE)) begin
            state_q <= pcs_pkg::ST_SAMPLE_SW;
            cnt_q <= pcs_pkg::TICK_ZERO;
        end else if (wr_rise) begin
            state_q <= pcs_pkg::ST_IDLE;
            cnt_q <= pcs_pkg::TICK_ZERO;
        end else begin
            case (state_q)
                pcs_pkg::ST_IDLE: begin
                    if (trig_fall && !cr0_q.trigger_source_sel) begin
                        state_q <= pcs_pkg::ST_SAMPLE_HW;
                    end
                end
                pcs_pkg::ST_SAMPLE_HW: begin
                    if (trig_rise) begin
                        state_q <= pcs_pkg::ST_CONVERT;
                        cnt_q <= pcs_pkg::TICK_ZERO;
                    end
                end
                pcs_pkg::ST_SAMPLE_SW: begin
                    if (conv_begin) begin
                        state_q <= pcs_pkg::ST_CONVERT;
                        cnt_q <= pcs_pkg::TICK_ZERO;
                    end else if (conv_tick) begin
                        cnt_q <= cnt_q + pcs_pkg::TICK_ONE;
                    end
                end
                pcs_pkg::ST_CONVERT: begin
                    if (conv_end) begin
                        state_q <= pcs_pkg::ST_IDLE;
                        cnt_q <= pcs_pkg::TICK_ZERO;
                    end else if (conv_tick) begin
                        cnt_q <= cnt_q + pcs_pkg::TICK_ONE;
                    end
                end
                default: begin
                    state_q <= pcs_pkg::ST_IDLE;
                    cnt_q <= pcs_pkg::TICK_ZERO;
                end
            endcase
        end
    end

    // Sample-and-hold control is high while either sampling state is active.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sample_hold <= 1'b0;
        end else begin
            sample_hold <= state_q == pcs_pkg::ST_SAMPLE_HW || state_q == pcs_pkg::ST_SAMPLE_SW;
        end
    end

    // ----------------------------------------------------------------
    // Channel selection
    // ----------------------------------------------------------------
    // Sweep sequences end on channel 1, 3, 5 or 7 after the low select bits.
    assign sweep_last = {cr0_q.channel_pick[1:0], 1'b1};

    // Single mode follows the select bits; sweep steps once per finished conversion.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mux_channel <= '0;
        end else if (!cr0_q.scan_mode_sel) begin
            mux_channel <= cr0_q.channel_pick;
        end else if (wr_rise) begin
            mux_channel <= '0;
        end else if (conv_end) begin
            if (mux_channel >= sweep_last) begin
                mux_channel <= '0;
            end else begin
                mux_channel <= mux_channel + 3'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Result code
    // ----------------------------------------------------------------
    // Quantiser model: clamps to the reference limits, else offset from the low one.
    always_comb begin
        if (ain_level >= ref_upper) begin
            adc_code = pcs_pkg::CODE_FULL;
        end else if (ain_level <= ref_lower) begin
            adc_code = pcs_pkg::CODE_ZERO;
        end else if ((ain_level - ref_lower) > AIN_W'(pcs_pkg::CODE_FULL)) begin
            adc_code = pcs_pkg::CODE_FULL;
        end else begin
            adc_code = pcs_pkg::DATA_W'(ain_level - ref_lower);
        end
    end

    assign test_sel = {cr1_q.selftest_sel_hi, cr1_q.selftest_sel_lo};

    // Self-test replaces the quantiser output unless read-back owns the select bits.
    always_comb begin
        conv_code = adc_code;
        if (!cr1_q.readback_enable) begin
            case (test_sel)
                pcs_pkg::TEST_LOW: conv_code = pcs_pkg::CODE_ZERO;
                pcs_pkg::TEST_MID: conv_code = pcs_pkg::CODE_MID;
                pcs_pkg::TEST_HIGH: conv_code = pcs_pkg::CODE_FULL;
                default: conv_code = adc_code;
            endcase
        end
        if (cr1_q.output_format_sel) begin
            conv_code[pcs_pkg::DATA_W-1] = ~conv_code[pcs_pkg::DATA_W-1];
        end
    end

    // The result is caught at the edge that ends the conversion.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result_q <= pcs_pkg::CODE_ZERO;
        end else if (conv_end) begin
            result_q <= conv_code;
        end
    end

    // ----------------------------------------------------------------
    // Completion output
    // ----------------------------------------------------------------
    // Interrupt style pulses low one clock; end style is low for the conversion.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_status_n <= 1'b1;
        end else if (!cr0_q.done_style_sel) begin
            conv_status_n <= !conv_end;
        end else if (conv_end || state_q != pcs_pkg::ST_CONVERT) begin
            conv_status_n <= 1'b1;
        end else begin
            conv_status_n <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Power-down status
    // ----------------------------------------------------------------
    // Auto power-down follows a completion that no read answers within one clock.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ap_cnt_q <= pcs_pkg::AUTO_PD_IDLE;
            auto_pd <= 1'b0;
        end else if (conv_end) begin
            ap_cnt_q <= pcs_pkg::AUTO_PD_ONE;
            auto_pd <= 1'b0;
        end else if (rd_fall || sw_start || trig_fall) begin
            ap_cnt_q <= pcs_pkg::AUTO_PD_IDLE;
            auto_pd <= 1'b0;
        end else if (ap_cnt_q == pcs_pkg::AUTO_PD_LAST) begin
            ap_cnt_q <= pcs_pkg::AUTO_PD_IDLE;
            auto_pd <= 1'b1;
        end else if (ap_cnt_q != pcs_pkg::AUTO_PD_IDLE) begin
            ap_cnt_q <= ap_cnt_q + pcs_pkg::AUTO_PD_ONE;
        end
    end

    // Software power-down follows chip select or the soft_pwdn bit; registers are left untouched.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            soft_pd <= 1'b0;
        end else begin
            soft_pd <= pd_now;
        end
    end

    // ----------------------------------------------------------------
    // Data bus
    // ----------------------------------------------------------------
    // Read-back returns the register with its address bits; other selects read zero.
    always_comb begin
        case (test_sel)
            pcs_pkg::TEST_NONE: readback_word = {pcs_pkg::ADDR_CR0, cr0_q};
            pcs_pkg::TEST_LOW: readback_word = {pcs_pkg::ADDR_CR1, cr1_q};
            default: readback_word = pcs_pkg::CODE_ZERO;
        endcase
    end

    // The bus is driven only while chip select and read are both low.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            data_oe <= 1'b0;
            data_out <= pcs_pkg::CODE_ZERO;
        end else begin
            data_oe <= !pins_s.cs_n && !pins_s.rd_n && pins_s.wr_n;
            data_out <= cr1_q.readback_enable ? readback_word : result_q;
        end
    end

endmodule // pcs_sequencer

// >>> tb/pcs_seq_chk_sva.sv
// Pin-level assertions of the conversion sequencer.
// Assumes a host that holds each pin level for several clocks.
`timescale 1ns/10ps
module pcs_seq_chk #(
    parameter int AIN_W = 12
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic hw_conv_trigger_n,
    input wire logic conv_clock,
    input wire logic [pcs_pkg::DATA_W-1:0] data_in,
    input wire logic [pcs_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic [AIN_W-1:0] ain_level,
    input wire logic [AIN_W-1:0] ref_upper,
    input wire logic [AIN_W-1:0] ref_lower,
    input wire logic conv_status_n,
    input wire logic [pcs_pkg::CH_W-1:0] mux_channel,
    input wire logic sample_hold,
    input wire logic osc_enable,
    input wire logic auto_pd,
    input wire logic soft_pd
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [4:0] low_cnt_q;
    // Counts how long the completion output has been low.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt_q <= 5'h00;
        end else begin
            low_cnt_q <= conv_status_n ? 5'h00 : low_cnt_q + 5'h01;
        end
    end
    a_pd_on_cs: assert property (cs_n [*8] |-> soft_pd)
        else $error("soft power-down missing");
    a_oe_off_cs: assert property (cs_n [*8] |-> !data_oe)
        else $error("bus driven while deselected");
    a_oe_needs_rd: assert property ($rose(data_oe) |-> $past(!rd_n, 2) && $past(!cs_n, 2))
        else $error("bus driven without a read");
    a_status_sampling: assert property (sample_hold |-> conv_status_n)
        else $error("completion low while sampling");
    a_chan_stable: assert property (sample_hold && $past(sample_hold) |-> $stable(mux_channel))
        else $error("channel moved while sampling");
    a_sample_bound: assert property (sample_hold && hw_conv_trigger_n |-> ##[1:10] !sample_hold)
        else $error("sampling too long");
    a_conv_time: assert property ($fell(sample_hold) ##0 (wr_n && !cs_n) [*8] |-> ##[1:5] $rose(conv_status_n))
        else $error("conversion length wrong");
    a_int_single: assert property ($fell(conv_status_n) ##1 $rose(conv_status_n) |-> conv_status_n [*6])
        else $error("extra completion pulse");
    a_eoc_bound: assert property (low_cnt_q <= 5'h0B)
        else $error("completion low too long");
    a_osc_stops: assert property ($rose(conv_status_n) |-> ##[1:3] !osc_enable)
        else $error("oscillator left running");
endmodule // pcs_seq_chk

bind pcs_sequencer pcs_seq_chk #(.AIN_W(AIN_W)) u_chk (.clk(clk), .rst_b(rst_b), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .hw_conv_trigger_n(hw_conv_trigger_n), .conv_clock(conv_clock), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .ain_level(ain_level), .ref_upper(ref_upper), .ref_lower(ref_lower),
    .conv_status_n(conv_status_n), .mux_channel(mux_channel), .sample_hold(sample_hold),
    .osc_enable(osc_enable), .auto_pd(auto_pd), .soft_pd(soft_pd));

// >>> tb/pcs_host_model.sv
// Host processor model that drives the converter's parallel pins.
// Assumes a 10 MHz clock; every strobe, select and start pin level is held six clocks or more.
`timescale 1ns/10ps
module pcs_host_model (
    input wire logic clk,
    input wire logic [pcs_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe,
    output logic cs_n = 1'b1,
    output logic wr_n = 1'b1,
    output logic rd_n = 1'b1,
    output logic trig_n = 1'b1,
    output logic [pcs_pkg::DATA_W-1:0] data_pin
);
    logic drv = 1'b0;
    logic [pcs_pkg::DATA_W-1:0] dq = 10'h000;
    // Released pins show the inverse of the last word.
    assign data_pin = data_oe ? data_out : (drv ? dq : ~dq);
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Chip select change, then the minimum power-down or resume time.
    task automatic set_cs(input logic v);
        @(posedge clk);
        cs_n <= v;
        cyc(4);
    endtask
    // Write cycle: address in the top two bits, contents below.
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        dq <= {a, v};
        drv <= 1'b1;
        wr_n <= 1'b0;
        cyc(6);
        wr_n <= 1'b1;
        cyc(6);
        drv <= 1'b0;
    endtask
    // Read cycle; an undriven bus returns unknown.
    task automatic rd(output logic [pcs_pkg::DATA_W-1:0] q);
        @(posedge clk);
        rd_n <= 1'b0;
        cyc(6);
        q = (data_oe === 1'b1) ? data_out : 'x;
        rd_n <= 1'b1;
        cyc(6);
    endtask
    // Hardware start pin level, held eight clocks.
    task automatic hold_trig(input logic v);
        @(posedge clk);
        trig_n <= v;
        cyc(8);
    endtask
endmodule // pcs_host_model

// >>> tb/testbench.sv
// Self-checking bench of the conversion sequencer with a host model.
// Assumes the host model owns the host pins; the bench sets the analog codes and drives the conversion clock.
`timescale 1ns/10ps
module testbench;
    logic [11:0] lo = 12'h100, up = 12'hC00;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] div_q = 2'h0;
    logic [11:0] ain = 12'h000;
    logic cs_n, wr_n, rd_n, trig_n, data_oe, status_n, hold, osc, apd, spd;
    logic [9:0] pins, dout, q;
    logic [2:0] chan, pick;
    logic [11:0] vals [5] = '{12'h050, 12'h100, 12'h101, 12'h4FF, 12'hC00};
    logic [9:0] codes [4] = '{10'h000, 10'h000, 10'h200, 10'h3FF};
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    // Slow external conversion clock source.
    always @(posedge clk) div_q <= div_q + 2'h1;
    pcs_sequencer DUT (.clk(clk), .rst_b(rst_b), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .hw_conv_trigger_n(trig_n), .conv_clock(div_q[1]), .data_in(pins), .data_out(dout), .data_oe(data_oe),
        .ain_level(ain), .ref_upper(up), .ref_lower(lo), .conv_status_n(status_n), .mux_channel(chan),
        .sample_hold(hold), .osc_enable(osc), .auto_pd(apd), .soft_pd(spd));
    pcs_host_model host (.clk(clk), .data_out(dout), .data_oe(data_oe), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .trig_n(trig_n), .data_pin(pins));
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Expected code: clamped at both reference limits.
    function automatic logic [9:0] exp_code(input logic [11:0] a);
        if (a >= up) return 10'h3FF;
        if (a <= lo) return 10'h000;
        return ((a - lo) > 12'h3FF) ? 10'h3FF : 10'(a - lo);
    endfunction
    // Waits a bounded time for a signal to reach a level.
    task automatic wait_lvl(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk({9'h000, s}, {9'h000, v}, "wait");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        void'($urandom(99));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        host.set_cs(1'b0);
        host.wr(2'h0, 8'h80);
        for (int k = 1; k < 12; k++) begin
            ain <= (k < 4) ? 12'h000 : ((k < 9) ? vals[k-4] : 12'($urandom));
            host.wr(2'h1, (k < 4) ? 8'(k) : 8'h00);
            wait_lvl(status_n, 1'b0);
            wait_lvl(status_n, 1'b1);
            host.rd(q);
            chk(q, (k < 4) ? codes[k] : exp_code(ain), "code");
        end
        $display("test codes done");
        host.wr(2'h1, 8'h04);
        wait_lvl(status_n, 1'b0);
        wait_lvl(status_n, 1'b1);
        host.cyc(4);
        chk({9'h000, apd}, 10'h001, "auto power-down");
        host.rd(q);
        chk(q, 10'h080, "register zero");
        host.wr(2'h1, 8'h05);
        wait_lvl(status_n, 1'b0);
        wait_lvl(status_n, 1'b1);
        host.rd(q);
        chk(q, 10'h105, "register one");
        $display("test readback done");
        host.wr(2'h1, 8'h00);
        wait_lvl(status_n, 1'b0);
        wait_lvl(status_n, 1'b1);
        ain <= 12'($urandom);
        host.wr(2'h0, 8'hC9);
        for (int k = 0; k < 6; k++) begin
            wait_lvl(hold, 1'b1);
            chk({7'h00, chan}, 10'(k % 4), "sweep channel");
            wait_lvl(status_n, 1'b0);
            wait_lvl(status_n, 1'b1);
            host.rd(q);
            chk(q, exp_code(ain), "sweep code");
        end
        $display("test sweep done");
        for (int k = 0; k < 3; k++) begin
            pick = 3'($urandom);
            {ain, lo} <= {12'($urandom), 12'($urandom) & 12'h3FF};
            host.wr(2'h0, {5'h00, pick});
            host.hold_trig(1'b0);
            chk({6'h00, hold, chan}, {7'h01, pick}, "hardware sampling");
            host.hold_trig(1'b1);
            wait_lvl(status_n, 1'b0);
            wait_lvl(status_n, 1'b1);
            host.rd(q);
            chk(q, exp_code(ain), "hardware code");
        end
        $display("test hardware start done");
        host.set_cs(1'b1);
        host.cyc(4);
        chk({8'h00, spd, data_oe}, 10'h002, "soft power-down");
        host.wr(2'h0, 8'h80);
        host.set_cs(1'b0);
        host.cyc(4);
        host.wr(2'h1, 8'h04);
        host.rd(q);
        chk(q, {7'h00, pick}, "held register");
        $display("test power-down done");
        close_out();
    end
endmodule // testbench
